// File: src/ube_encoder.sv
// Added by the designer: the plain strobed port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module ube_encoder #(
  parameter int T_MAX = 10,
  parameter int N_TAPS = 8,
  parameter int PRE_BITS = 1024
) (
  // Clock and reset
  input wire logic CLK_IN,
  input wire logic RESETN_IN,
  // Register port
  input wire logic [7:0] ADDR_IN,
  input wire logic [31:0] WDATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  output logic [31:0] RDATA_OUT,
  // Serial data from the MAC
  input wire logic DATA_IN,
  input wire logic DATA_VALID_IN,
  output logic DATA_READY_OUT,
  // Serial stream to the symbol mapper
  output logic TX_BIT_OUT,
  output logic TX_VALID_OUT,
  output logic TX_PREAMBLE_OUT,
  // Pre-equalized symbol axes
  output logic [15:0] EQ_I_OUT,
  output logic [15:0] EQ_Q_OUT
);

  localparam int NP = 2 * T_MAX;

  if (T_MAX < 1 || T_MAX > 10 || N_TAPS != 8 || PRE_BITS != 1024)
  begin : g_chk
    $error("ube_encoder parameters outside supported range");
  end

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  ube_pkg::ube_state_t state_q, state_d;
  logic [3:0] t_q, t_w;
  logic [7:0] k_q, k_w, k_max;
  logic short_q, scr_en_q, qam16_q;
  logic [14:0] seed_q, scr_q;
  logic [10:0] pre_len_q, len_w, cnt_q;
  logic [9:0] pre_off_q, ptr_q, pat_addr;
  logic [15:0] blen_q, rem_q;
  logic [7:0] cw_q;
  logic [2:0] bit_q;
  logic [6:0] sh_q;
  logic [7:0] g_q [NP+1];
  logic [7:0] p_q [NP];
  logic [7:0] root_q, fb, par_top;
  logic [4:0] nsym, gen_len;
  logic fec, take, bit_ev, in_bit, byte_end, scr_fb, data_bit, pre_bit, cfg_we, start_w;
  logic tx_bit_q, tx_val_q, tx_pre_q, ready_q;
  logic [31:0] rdata_q, rd_val;
  logic signed [15:0] coef_q [N_TAPS];
  logic signed [15:0] new_q [N_TAPS];
  logic signed [15:0] res_q [N_TAPS];
  logic signed [39:0] acc_q, acc_d;
  logic signed [31:0] prod;
  logic signed [15:0] conv_sat;
  logic [5:0] cv_q;
  logic [2:0] cn, cm, main_d, main_q;
  logic eq_busy_q, eq_init_w, eq_app_w, coef_sel;
  logic [15:0] gain_q;
  logic signed [39:0] gain_d, sum_i, sum_q;
  logic [N_TAPS-1:0] di_q, dq_q;
  logic [1:0] sbit_q;
  logic si_q;
  logic signed [15:0] eq_i_q, eq_q_q;

  // ----------------------------------------------------------------
  // Register writes, refused while a burst runs
  // ----------------------------------------------------------------
  assign cfg_we = WR_IN && (state_q == ube_pkg::S_IDLE);
  assign start_w = cfg_we && (ADDR_IN == ube_pkg::A_CTRL) && WDATA_IN[ube_pkg::C_START];
  assign t_w = (WDATA_IN[3:0] > 4'(T_MAX)) ? 4'(T_MAX) : WDATA_IN[3:0];
  assign k_max = ube_pkg::CW_MAX - {3'h0, t_w, 1'b0};
  assign k_w = (WDATA_IN[15:8] < ube_pkg::K_MIN) ? ube_pkg::K_MIN :
               (WDATA_IN[15:8] > k_max) ? k_max : WDATA_IN[15:8];
  assign len_w = ((WDATA_IN[10:0] > ube_pkg::PRE_MAX) ? ube_pkg::PRE_MAX : WDATA_IN[10:0]) &
                 (WDATA_IN[ube_pkg::P_QAM] ? 11'h7FC : 11'h7FE);

  always_ff @(posedge CLK_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
    begin
      t_q <= ube_pkg::T_RST;
      k_q <= ube_pkg::K_RST;
      short_q <= 1'b0;
      scr_en_q <= 1'b0;
      qam16_q <= 1'b0;
      seed_q <= ube_pkg::SEED_RST;
      pre_len_q <= 11'h000;
      pre_off_q <= 10'h000;
      blen_q <= ube_pkg::BLEN_RST;
    end
    else if (cfg_we)
    begin
      if (ADDR_IN == ube_pkg::A_CTRL)
      begin
        short_q <= WDATA_IN[ube_pkg::C_SHORT];
        scr_en_q <= WDATA_IN[ube_pkg::C_SCR];
      end
      else if (ADDR_IN == ube_pkg::A_FEC)
      begin
        t_q <= t_w;
        k_q <= k_w;
      end
      else if (ADDR_IN == ube_pkg::A_SEED)
        seed_q <= WDATA_IN[14:0];
      else if (ADDR_IN == ube_pkg::A_PRE)
      begin
        pre_len_q <= len_w;
        qam16_q <= WDATA_IN[ube_pkg::P_QAM];
        pre_off_q <= WDATA_IN[ube_pkg::P_OFF_LSB +: 10];
      end
      else if (ADDR_IN == ube_pkg::A_BLEN)
        blen_q <= (WDATA_IN[15:0] == 16'h0000) ? ube_pkg::BLEN_RST : WDATA_IN[15:0];
    end
  end

  // ----------------------------------------------------------------
  // Burst sequencer
  // ----------------------------------------------------------------
  assign fec = (t_q != 4'h0);
  assign nsym = {t_q, 1'b0};
  assign gen_len = fec ? nsym : 5'h01;
  assign take = (state_q == ube_pkg::S_INFO) && DATA_VALID_IN;
  assign bit_ev = take || (state_q == ube_pkg::S_PAD);
  assign in_bit = (state_q == ube_pkg::S_INFO) && DATA_IN;
  assign byte_end = bit_ev && (bit_q == 3'h7);
  assign scr_fb = scr_q[14] ^ scr_q[13];
  assign par_top = p_q[nsym - 5'h01];
  assign fb = {sh_q, in_bit} ^ par_top;
  assign data_bit = (state_q == ube_pkg::S_PAR) ? par_top[3'h7 - bit_q] : in_bit;

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ube_pkg::S_IDLE:
        if (start_w)
          state_d = ube_pkg::S_GEN;
      ube_pkg::S_GEN:
        if (cnt_q[4:0] == gen_len - 5'h01)
          state_d = (pre_len_q != 11'h000) ? ube_pkg::S_PRE : ube_pkg::S_INFO;
      ube_pkg::S_PRE:
        if (cnt_q == pre_len_q - 11'h001)
          state_d = ube_pkg::S_INFO;
      ube_pkg::S_INFO, ube_pkg::S_PAD:
        if (byte_end)
        begin
          if (fec && (cw_q == k_q - 8'h01))
            state_d = ube_pkg::S_PAR;
          else if ((state_q == ube_pkg::S_INFO) && (rem_q == 16'h0001))
            state_d = !fec ? ube_pkg::S_IDLE : short_q ? ube_pkg::S_PAR : ube_pkg::S_PAD;
        end
      ube_pkg::S_PAR:
        if (cnt_q[7:0] == {nsym, 3'h0} - 8'h01)
          state_d = (rem_q == 16'h0000) ? ube_pkg::S_IDLE : ube_pkg::S_INFO;
      default:
        state_d = ube_pkg::S_IDLE;
    endcase
  end

  always_ff @(posedge CLK_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
    begin
      state_q <= ube_pkg::S_IDLE;
      cnt_q <= 11'h000;
      ready_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= (state_d != state_q) ? 11'h000 : cnt_q + 11'h001;
      ready_q <= (state_d == ube_pkg::S_INFO);
    end
  end

  // ----------------------------------------------------------------
  // Byte assembly, codeword counting and the preamble pointer
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
    begin
      bit_q <= 3'h0;
      sh_q <= 7'h00;
      rem_q <= 16'h0000;
      cw_q <= 8'h00;
      ptr_q <= 10'h000;
    end
    else if (start_w)
    begin
      bit_q <= 3'h0;
      rem_q <= blen_q;
      cw_q <= 8'h00;
      ptr_q <= pre_off_q;
    end
    else
    begin
      if (state_q == ube_pkg::S_PRE)
        ptr_q <= ptr_q + 10'h001;
      if (bit_ev || (state_q == ube_pkg::S_PAR))
        bit_q <= bit_q + 3'h1;
      if (bit_ev)
        sh_q <= {sh_q[5:0], in_bit};
      if (byte_end && (state_q == ube_pkg::S_INFO))
        rem_q <= rem_q - 16'h0001;
      if (state_d == ube_pkg::S_PAR)
        cw_q <= 8'h00;
      else if (byte_end)
        cw_q <= cw_q + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // Reed-Solomon generator build and parity register
  // ----------------------------------------------------------------
  // The generator is rebuilt at every burst so T may change between bursts
  // at the cost of 2T idle cycles (one in bypass) before the preamble.
  always_ff @(posedge CLK_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
    begin
      root_q <= 8'h01;
      for (int i = 0; i <= NP; i++)
        g_q[i] <= 8'h00;
      for (int i = 0; i < NP; i++)
        p_q[i] <= 8'h00;
    end
    else if (start_w)
    begin
      root_q <= 8'h01;
      for (int i = 0; i <= NP; i++)
        g_q[i] <= (i == 0) ? 8'h01 : 8'h00;
      for (int i = 0; i < NP; i++)
        p_q[i] <= 8'h00;
    end
    else if (state_q == ube_pkg::S_GEN)
    begin
      root_q <= ube_pkg::gf_mul(root_q, ube_pkg::ALPHA);
      g_q[0] <= ube_pkg::gf_mul(g_q[0], root_q);
      for (int i = 1; i <= NP; i++)
        g_q[i] <= g_q[i-1] ^ ube_pkg::gf_mul(g_q[i], root_q);
    end
    else if (fec && byte_end)
    begin
      p_q[0] <= ube_pkg::gf_mul(fb, g_q[0]);
      for (int i = 1; i < NP; i++)
        p_q[i] <= (5'(i) < nsym) ? (p_q[i-1] ^ ube_pkg::gf_mul(fb, g_q[i])) : 8'h00;
    end
    else if ((state_q == ube_pkg::S_PAR) && (bit_q == 3'h7))
    begin
      p_q[0] <= 8'h00;
      for (int i = 1; i < NP; i++)
        p_q[i] <= p_q[i-1];
    end
  end

  // ----------------------------------------------------------------
  // Scrambler and output stream
  // ----------------------------------------------------------------
  // The pattern memory answers one cycle late, so it is addressed one bit
  // ahead while the preamble streams; otherwise the first bit repeats.
  assign pat_addr = ptr_q + {9'h000, (state_q == ube_pkg::S_PRE)};

  ube_mem #(.W(1), .D(PRE_BITS), .AW(10)) u_pat (
    .clk_in(CLK_IN),
    .we_in(cfg_we && (ADDR_IN == ube_pkg::A_PATW)),
    .waddr_in(WDATA_IN[9:0]),
    .wdata_in(WDATA_IN[ube_pkg::W_DATA]),
    .raddr_in(pat_addr),
    .rdata_out(pre_bit)
  );

  always_ff @(posedge CLK_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
      scr_q <= 15'h0000;
    else if (start_w)
      scr_q <= seed_q;
    else if (bit_ev || (state_q == ube_pkg::S_PAR))
      scr_q <= {scr_q[13:0], scr_fb};
  end

  always_ff @(posedge CLK_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
    begin
      tx_bit_q <= 1'b0;
      tx_val_q <= 1'b0;
      tx_pre_q <= 1'b0;
    end
    else
    begin
      tx_val_q <= (state_q == ube_pkg::S_PRE) || bit_ev || (state_q == ube_pkg::S_PAR);
      tx_pre_q <= (state_q == ube_pkg::S_PRE);
      if (state_q == ube_pkg::S_PRE)
        tx_bit_q <= pre_bit;
      else
        tx_bit_q <= data_bit ^ (scr_en_q & scr_fb);
    end
  end

  // ----------------------------------------------------------------
  // Equalizer coefficients: staging, convolution, initialisation
  // ----------------------------------------------------------------
  assign coef_sel = (ADDR_IN & ube_pkg::COEF_MASK) == ube_pkg::A_COEF;
  assign eq_init_w = WR_IN && (ADDR_IN == ube_pkg::A_CTRL) && WDATA_IN[ube_pkg::C_EQINIT];
  assign eq_app_w = WR_IN && (ADDR_IN == ube_pkg::A_CTRL) && WDATA_IN[ube_pkg::C_EQAPPLY];
  assign cn = cv_q[5:3];
  assign cm = cv_q[2:0];
  assign prod = (cm <= cn) ? new_q[cm] * coef_q[3'(cn - cm)] : 32'sh00000000;
  assign acc_d = ((cm == 3'h0) ? 40'sh0000000000 : acc_q) + 40'(prod);
  assign conv_sat = ube_pkg::sat16(acc_d >>> ube_pkg::FRAC);

  always_ff @(posedge CLK_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
    begin
      for (int i = 0; i < N_TAPS; i++)
        new_q[i] <= 16'h0000;
    end
    else if (WR_IN && coef_sel)
      new_q[ADDR_IN[4:2]] <= WDATA_IN[15:0];
  end

  always_ff @(posedge CLK_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
    begin
      eq_busy_q <= 1'b0;
      cv_q <= 6'h00;
      acc_q <= 40'sh0000000000;
      for (int i = 0; i < N_TAPS; i++)
      begin
        coef_q[i] <= (i == 0) ? ube_pkg::UNITY : 16'sh0000;
        res_q[i] <= 16'sh0000;
      end
    end
    else if (eq_init_w)
    begin
      eq_busy_q <= 1'b0;
      for (int i = 0; i < N_TAPS; i++)
        coef_q[i] <= (i == 0) ? ube_pkg::UNITY : 16'sh0000;
    end
    else if (eq_app_w && !eq_busy_q)
    begin
      eq_busy_q <= 1'b1;
      cv_q <= 6'h00;
    end
    else if (eq_busy_q)
    begin
      acc_q <= acc_d;
      cv_q <= cv_q + 6'h01;
      if (cm == 3'h7)
        res_q[cn] <= conv_sat;
      if (cv_q == ube_pkg::CONV_LAST)
      begin
        eq_busy_q <= 1'b0;
        for (int i = 0; i < N_TAPS; i++)
          coef_q[i] <= (i == N_TAPS - 1) ? conv_sat : res_q[i];
      end
    end
  end

  // Main tap is the largest magnitude; its index is the ranging correction
  // in symbols that software adds, and gain lets it trim transmit power.
  always_comb
  begin
    main_d = 3'h0;
    gain_d = 40'sh0000000000;
    for (int i = 0; i < N_TAPS; i++)
    begin
      gain_d = gain_d + 40'(coef_q[i] * coef_q[i]);
      if ((coef_q[i] < 0 ? -coef_q[i] : coef_q[i]) >
          (coef_q[main_d] < 0 ? -coef_q[main_d] : coef_q[main_d]))
        main_d = 3'(i);
    end
  end

  // ----------------------------------------------------------------
  // Symbol-spaced filter over the mapped axis signs
  // ----------------------------------------------------------------
  always_comb
  begin
    sum_i = 40'sh0000000000;
    sum_q = 40'sh0000000000;
    for (int i = 0; i < N_TAPS; i++)
    begin
      sum_i = sum_i + (di_q[i] ? -40'(coef_q[i]) : 40'(coef_q[i]));
      sum_q = sum_q + (dq_q[i] ? -40'(coef_q[i]) : 40'(coef_q[i]));
    end
  end

  always_ff @(posedge CLK_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
    begin
      sbit_q <= 2'h0;
      si_q <= 1'b0;
      di_q <= '0;
      dq_q <= '0;
      eq_i_q <= 16'sh0000;
      eq_q_q <= 16'sh0000;
      main_q <= 3'h0;
      gain_q <= 16'h0000;
    end
    else
    begin
      main_q <= main_d;
      gain_q <= ube_pkg::sat16(gain_d >>> ube_pkg::FRAC);
      eq_i_q <= ube_pkg::sat16(sum_i);
      eq_q_q <= ube_pkg::sat16(sum_q);
      if (tx_val_q)
      begin
        sbit_q <= (sbit_q == (qam16_q ? 2'h3 : 2'h1)) ? 2'h0 : sbit_q + 2'h1;
        if (sbit_q == 2'h0)
          si_q <= tx_bit_q;
        if (sbit_q == 2'h1)
        begin
          di_q <= {di_q[N_TAPS-2:0], si_q};
          dq_q <= {dq_q[N_TAPS-2:0], tx_bit_q};
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------
  always_comb
  begin
    rd_val = 32'h00000000;
    if (ADDR_IN == ube_pkg::A_CTRL)
      rd_val = {27'h0, 2'h0, scr_en_q, short_q, 1'b0};
    else if (ADDR_IN == ube_pkg::A_FEC)
      rd_val = {16'h0, k_q, 4'h0, t_q};
    else if (ADDR_IN == ube_pkg::A_SEED)
      rd_val = {17'h0, seed_q};
    else if (ADDR_IN == ube_pkg::A_PRE)
      rd_val = {6'h0, pre_off_q, 3'h0, qam16_q, 1'b0, pre_len_q};
    else if (ADDR_IN == ube_pkg::A_BLEN)
      rd_val = {16'h0, blen_q};
    else if (ADDR_IN == ube_pkg::A_STAT)
      rd_val = {gain_q, 9'h0, main_q, 2'h0, eq_busy_q, state_q != ube_pkg::S_IDLE};
    else if (coef_sel)
      rd_val = {16'h0, coef_q[ADDR_IN[4:2]]};
  end

  always_ff @(posedge CLK_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
      rdata_q <= 32'h00000000;
    else
      rdata_q <= RD_IN ? rd_val : 32'h00000000;
  end

  assign RDATA_OUT = rdata_q;
  assign DATA_READY_OUT = ready_q;
  assign TX_BIT_OUT = tx_bit_q;
  assign TX_VALID_OUT = tx_val_q;
  assign TX_PREAMBLE_OUT = tx_pre_q;
  assign EQ_I_OUT = eq_i_q;
  assign EQ_Q_OUT = eq_q_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (!RESETN_IN);

  sequence s_start;
    (state_q == ube_pkg::S_IDLE) && start_w;
  endsequence
  sequence s_conv;
    $rose(eq_busy_q) ##63 eq_busy_q;
  endsequence

  AST_SEED_LOAD: assert property (s_start |=> scr_q == $past(seed_q))
    else $error("scrambler not seeded at burst start");
  AST_PRE_HOLD: assert property ((state_q == ube_pkg::S_PRE) |=> $stable(scr_q))
    else $error("scrambler moved during preamble");
  AST_SCR_STEP: assert property (bit_ev |=> scr_q == {$past(scr_q[13:0]), $past(scr_fb)})
    else $error("scrambler step wrong");
  AST_PRE_FIRST: assert property ((tx_val_q && !tx_pre_q) |=> !tx_pre_q)
    else $error("preamble after data");
  AST_PASS: assert property ((take && !scr_en_q) |=> tx_val_q && tx_bit_q == $past(DATA_IN))
    else $error("data bit not passed through");
  AST_PAR_LEN: assert property ($rose(state_q == ube_pkg::S_PAR) |-> cnt_q == 11'h000 && fec)
    else $error("parity phase entry wrong");
  AST_INIT: assert property (eq_init_w |=> coef_q[0] == ube_pkg::UNITY && coef_q[1] == 16'sh0)
    else $error("equalizer init wrong");
  AST_CONV: assert property (s_conv |=> !eq_busy_q)
    else $error("convolution not 64 cycles");
  AST_PRE_LEN: assert property (pre_len_q <= ube_pkg::PRE_MAX && !pre_len_q[0])
    else $error("preamble length illegal");
  AST_K_RANGE: assert property (k_q >= ube_pkg::K_MIN && t_q <= 4'(T_MAX))
    else $error("codeword size out of range");

endmodule : ube_encoder
`default_nettype wire

// File: src/ube_mem.sv
`timescale 1ns/10ps
`default_nettype none
module ube_mem #(
  parameter int W = 1,
  parameter int D = 1024,
  parameter int AW = 10
) (
  // Clock
  input wire logic clk_in,
  // Write port
  input wire logic we_in,
  input wire logic [AW-1:0] waddr_in,
  input wire logic [W-1:0] wdata_in,
  // Read port, data one cycle after the address
  input wire logic [AW-1:0] raddr_in,
  output logic [W-1:0] rdata_out
);

  logic [W-1:0] mem [D];

  if (D > (1 << AW))
  begin : g_chk
    $error("ube_mem depth exceeds address range");
  end

  always_ff @(posedge clk_in)
  begin
    if (we_in)
      mem[waddr_in] <= wdata_in;
    rdata_out <= mem[raddr_in];
  end

endmodule : ube_mem
`default_nettype wire

// File: src/ube_pkg.sv
// Notes on behaviour
// - Reed-Solomon T=1..10 over GF(256), or bypass.
// - Generator roots alpha^0..alpha^(2T-1), alpha=2.
// - Field polynomial x^8+x^4+x^3+x^2+1.
// - Codewords 18..255 bytes; uncoded down to one byte.
// - Shortened mode trims only the last codeword.
// - T, seed, preamble length and value are loadable.
// - First input bit lands in symbol MSB.
// - Encoder output leaves MSB first to scrambler.
// - Scrambler seed is any 15-bit value.
// - Seed reloaded each burst; preamble stays unscrambled.
// - Scrambler polynomial x^15+x^14+1.
// - Preamble goes ahead of coded, scrambled data.
// - Preamble starts at programmable pattern offset.
// - Preamble length even/multiple of four, max 1024.
// - Eight-tap symbol-spaced linear pre-equalizer.
// - Coefficients are s1.14 two's complement.
// - New coefficients convolved with current set.
// - Coefficient reset: only first tap real unity.
// - Ranging offset follows main tap shift.
// - Coefficients saturate; gain reported for power.
// - Same tap count keeps main tap in place.
// - Serial stream to mapper is MSB first.
`default_nettype none
package ube_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_FEC = 8'h04;
  localparam logic [7:0] A_SEED = 8'h08;
  localparam logic [7:0] A_PRE = 8'h0C;
  localparam logic [7:0] A_BLEN = 8'h10;
  localparam logic [7:0] A_STAT = 8'h14;
  localparam logic [7:0] A_PATW = 8'h18;
  localparam logic [7:0] A_COEF = 8'h40;
  localparam logic [7:0] COEF_MASK = 8'hE0;
  localparam int C_START = 0;
  localparam int C_SHORT = 1;
  localparam int C_SCR = 2;
  localparam int C_EQINIT = 3;
  localparam int C_EQAPPLY = 4;
  localparam int F_K_LSB = 8;
  localparam int P_QAM = 12;
  localparam int P_OFF_LSB = 16;
  localparam int W_DATA = 31;
  localparam int S_MAIN_LSB = 4;
  localparam int S_GAIN_LSB = 16;

  // ----------------------------------------------------------------
  // Reset values and limits
  // ----------------------------------------------------------------
  localparam logic [3:0] T_RST = 4'h0;
  localparam logic [7:0] K_RST = 8'h10;
  localparam logic [7:0] K_MIN = 8'h10;
  localparam logic [7:0] CW_MAX = 8'hFF;
  localparam logic [14:0] SEED_RST = 15'h0001;
  localparam logic [15:0] BLEN_RST = 16'h0001;
  localparam logic [10:0] PRE_MAX = 11'h400;
  localparam logic [7:0] GF_POLY = 8'h1D;
  localparam logic [7:0] ALPHA = 8'h02;
  localparam int FRAC = 14;
  localparam logic signed [15:0] UNITY = 16'h4000;
  localparam logic [5:0] CONV_LAST = 6'h3F;

  typedef enum logic [2:0] {S_IDLE, S_GEN, S_PRE, S_INFO, S_PAD, S_PAR} ube_state_t;

  function automatic logic [7:0] gf_mul(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] r;
    logic [7:0] x;
    r = 8'h00;
    x = a;
    for (int i = 0; i < 8; i++)
    begin
      if (b[i])
        r = r ^ x;
      x = x[7] ? ({x[6:0], 1'b0} ^ GF_POLY) : {x[6:0], 1'b0};
    end
    return r;
  endfunction : gf_mul

  function automatic logic signed [15:0] sat16(input logic signed [39:0] v);
    if (v > 40'sh0000007FFF)
      return 16'h7FFF;
    else if (v < -40'sh0000008000)
      return 16'h8000;
    else
      return v[15:0];
  endfunction : sat16

endpackage : ube_pkg
`default_nettype wire

// File: verification/ube_mac_model.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------
// Serial bit source standing in for the MAC
// ----------------------------------------------------------------
module ube_mac_model (
  // Clock and control
  input wire logic clk_in,
  input wire logic load_in,
  input wire logic slow_in,
  input wire logic [7:0] byte_in,
  // Link to the encoder
  input wire logic ready_in,
  output logic data_out,
  output logic valid_out
);
  logic [7:0] sr_q = 8'h00;
  logic [3:0] cnt_q = 4'h0;
  logic ph_q = 1'b0;
  logic last_q = 1'b0;
  // An idle line shows the inverse of the last bit, so stale data never matches by luck.
  assign valid_out = (cnt_q != 4'h0) && (!slow_in || ph_q);
  assign data_out = valid_out ? sr_q[7] : ~last_q;
  always_ff @(posedge clk_in)
  begin
    ph_q <= ~ph_q;
    if (load_in)
    begin
      sr_q <= byte_in;
      cnt_q <= 4'h8;
    end
    else if (valid_out && ready_in)
    begin
      sr_q <= {sr_q[6:0], 1'b0};
      cnt_q <= cnt_q - 4'h1;
      last_q <= sr_q[7];
    end
  end
endmodule : ube_mac_model
`default_nettype wire

// File: verification/upstream_burst_encoder_bench.sv
`timescale 1ns/10ps
`default_nettype none
module upstream_burst_encoder_bench;
  logic CLK_IN = 1'b0;
  logic RESETN_IN, WR_IN, RD_IN, DIN, DV, DRDY, TXB, TXV, TXP, load, slow;
  logic [7:0] ADDR_IN, mbyte, pat;
  logic [31:0] WDATA_IN, RDATA_OUT, s;
  logic [1:0] exp_q[$];
  logic [14:0] sd;
  logic [15:0] EQI, EQQ;
  int mismatches = 0;
  int compares = 0;
  int seed = 56;
  always #12.5 CLK_IN = ~CLK_IN;
  ube_encoder DUT (.CLK_IN(CLK_IN), .RESETN_IN(RESETN_IN), .ADDR_IN(ADDR_IN),
    .WDATA_IN(WDATA_IN), .WR_IN(WR_IN), .RD_IN(RD_IN), .RDATA_OUT(RDATA_OUT),
    .DATA_IN(DIN), .DATA_VALID_IN(DV), .DATA_READY_OUT(DRDY), .TX_BIT_OUT(TXB),
    .TX_VALID_OUT(TXV), .TX_PREAMBLE_OUT(TXP), .EQ_I_OUT(EQI), .EQ_Q_OUT(EQQ));
  ube_mac_model mac (.clk_in(CLK_IN), .load_in(load), .slow_in(slow), .byte_in(mbyte),
    .ready_in(DRDY), .data_out(DIN), .valid_out(DV));
  // ----------------------------------------------------------------
  // Checking and bus tasks
  // ----------------------------------------------------------------
  task automatic tally_and_finish;
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    compares++;
    if (seen !== want)
    begin
      mismatches++;
      $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK_IN);
    ADDR_IN <= a;
    WDATA_IN <= d;
    WR_IN <= 1'b1;
    @(posedge CLK_IN);
    WR_IN <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge CLK_IN);
    ADDR_IN <= a;
    RD_IN <= 1'b1;
    @(posedge CLK_IN);
    RD_IN <= 1'b0;
    #1 s = RDATA_OUT;
  endtask : rd
  task automatic rchk(input logic [7:0] a, input logic [31:0] want);
    rd(a);
    check(s, want);
  endtask : rchk
  task automatic wait_idle;
    for (int i = 0; i < 2000; i++)
    begin
      rd(ube_pkg::A_STAT);
      if (s[1:0] === 2'b00)
        return;
    end
    mismatches++;
    tally_and_finish();
  endtask : wait_idle
  // Expected bits are queued before the burst starts; the monitor pops them.
  task automatic burst(input logic scr, input logic sl, input int len, input int off,
                       input logic fe);
    logic [7:0] b;
    logic [7:0] x;
    logic [23:0] v;
    logic [14:0] r;
    logic f;
    b = 8'($random(seed));
    // A shortened one-byte codeword with T=1 carries parity 3b, then 2b.
    x = {b[6:0], 1'b0} ^ (b[7] ? ube_pkg::GF_POLY : 8'h00);
    v = {b, x ^ b, x};
    r = sd;
    for (int i = 0; i < len; i++)
      exp_q.push_back({1'b1, pat[off + i]});
    for (int i = 23; i >= (fe ? 0 : 16); i--)
    begin
      f = r[14] ^ r[13];
      exp_q.push_back({1'b0, v[i] ^ (scr & f)});
      r = {r[13:0], f};
    end
    wr(ube_pkg::A_SEED, {17'h00000, sd});
    wr(ube_pkg::A_PRE, 32'(off << 16) | 32'(len));
    wr(ube_pkg::A_BLEN, 32'h00000001);
    wr(ube_pkg::A_FEC, {28'h0000100, 3'h0, fe});
    @(posedge CLK_IN);
    load <= 1'b1;
    mbyte <= b;
    slow <= sl;
    @(posedge CLK_IN);
    load <= 1'b0;
    wr(ube_pkg::A_CTRL, {29'h00000000, scr, fe, 1'b1});
    wait_idle();
  endtask : burst
  always @(posedge CLK_IN)
    if (TXV === 1'b1)
      check({TXP, TXB}, exp_q.size() > 0 ? exp_q.pop_front() : 2'bxx);
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    RESETN_IN = 1'b0;
    {WR_IN, RD_IN, load, slow} = 4'h0;
    ADDR_IN = 8'h00;
    WDATA_IN = 32'h00000000;
    mbyte = 8'h00;
    repeat (16) @(posedge CLK_IN);
    RESETN_IN <= 1'b1;
    rchk(ube_pkg::A_FEC, {16'h0000, ube_pkg::K_RST, 4'h0, ube_pkg::T_RST});
    rchk(ube_pkg::A_SEED, {17'h00000, ube_pkg::SEED_RST});
    rchk(8'h20, 32'h00000000);
    rchk(ube_pkg::A_COEF, 32'h00004000);
    rchk(ube_pkg::A_STAT, 32'h40000000);
    check({EQI, EQQ}, 32'h40004000);
    wr(ube_pkg::A_FEC, 32'h0000080F);
    rchk(ube_pkg::A_FEC, 32'h0000100A);
    wr(ube_pkg::A_PRE, 32'h000017FF);
    rchk(ube_pkg::A_PRE, 32'h00001400);
    wr(ube_pkg::A_PRE, 32'h00001007);
    rchk(ube_pkg::A_PRE, 32'h00001004);
    wr(ube_pkg::A_COEF, 32'h00004000);
    wr(ube_pkg::A_COEF + 8'h04, 32'h00001234);
    wr(ube_pkg::A_CTRL, 32'h00000010);
    wait_idle();
    rchk(ube_pkg::A_COEF + 8'h04, 32'h00001234);
    check({EQI, EQQ}, 32'h52345234);
    wr(ube_pkg::A_CTRL, 32'h00000008);
    wait_idle();
    rchk(ube_pkg::A_COEF + 8'h04, 32'h00000000);
    pat = 8'($random(seed));
    for (int i = 0; i < 8; i++)
      wr(ube_pkg::A_PATW, {pat[i], 21'h000000, 10'(i)});
    sd = 15'($random(seed));
    burst(1'b0, 1'b1, 0, 0, 1'b0);
    burst(1'b1, 1'b0, 4, 2, 1'b0);
    burst(1'b1, 1'b1, 4, 2, 1'b1);
    burst(1'b0, 1'b0, 2, 5, 1'b1);
    repeat (4) @(posedge CLK_IN);
    check(32'(exp_q.size()), 32'h00000000);
    tally_and_finish();
  end
endmodule : upstream_burst_encoder_bench
`default_nettype wire
